// file: tb/cip_host_model.sv
// Host model that masters the two-wire bus
`timescale 1ns/10ps
module cip_host_model (
    output reg scl,
    output reg pull,
    input wire sda
);
// Idle bus: clock high, data left to the pull-up
initial begin
    scl = 1'b1;
    pull = 1'b0;
end
// ==========================================
// Start or repeated start: data falls while clock is high
task start;
    begin
        pull = 1'b0;
        #200 scl = 1'b1;
        #400 pull = 1'b1;
        #400 scl = 1'b0;
        #200;
    end
endtask
task bitx(input b, output r);
    begin
        pull = !b;
        #200 scl = 1'b1;
        #350 r = sda;
        #50 scl = 1'b0;
        #200;
    end
endtask
task xfer(input [7:0] d, input ackIn, output [7:0] q, output ack);
    integer i;
    reg b;
    begin
        for (i = 7; i >= 0; i = i - 1) begin
            bitx(d[i], b);
            q[i] = b;
        end
        bitx(ackIn, ack);
    end
endtask
// Stop: data rises while clock is high
task stop;
    begin
        pull = 1'b1;
        #200 scl = 1'b1;
        #400 pull = 1'b0;
        #400;
    end
endtask
endmodule // cip_host_model

// file: tb/cip_port_chk_chk.sv
// Assertion checker for the charger two-wire register port
`timescale 1ns/10ps
module cip_port_chk (
    input wire clock,
    input wire rst_n,
    input wire sdaOut,
    input wire sdaOe,
    input wire chargeEnablePinN,
    input wire detectDone,
    input wire [4:0] detectLimit,
    input wire watchdogExpired,
    input wire inputHighImpedanceEnable,
    input wire [4:0] inputCurrentLimit,
    input wire boostSourceEnable,
    input wire chargeActive,
    input wire watchdogRestartPulse,
    input wire [7:0] registerPointer
);
default clocking cb @(posedge clock); endclocking
default disable iff (!rst_n);
// ==========================================
// Bus pin behaviour
property p_sda_low; sdaOut == 1'b0; endproperty
a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
property p_ack_stand; $rose(sdaOe) |=> sdaOe [*2]; endproperty
a_ack_stand: assert property (p_ack_stand) else $error("acknowledge too short");
// ==========================================
// Register side effects
property p_wdr_pulse; watchdogRestartPulse |=> !watchdogRestartPulse; endproperty
a_wdr_pulse: assert property (p_wdr_pulse) else $error("restart pulse too long");
property p_boost_prio; boostSourceEnable && $past(boostSourceEnable) |-> !chargeActive; endproperty
a_boost_prio: assert property (p_boost_prio) else $error("charge while boost");
property p_pin_off; chargeEnablePinN [*6] |-> !chargeActive; endproperty
a_pin_off: assert property (p_pin_off) else $error("charge with pin high");
property p_detect; detectDone |-> ##2 inputCurrentLimit == $past(detectLimit, 2); endproperty
a_detect: assert property (p_detect) else $error("detect limit not loaded");
property p_wd_exp; watchdogExpired |-> ##2 !inputHighImpedanceEnable && !boostSourceEnable; endproperty
a_wd_exp: assert property (p_wd_exp) else $error("expiry fields kept");
property p_skip_fault; registerPointer == 8'h08 |=> registerPointer inside {8'h08, 8'h0a}; endproperty
a_skip_fault: assert property (p_skip_fault) else $error("fault register not skipped");
property p_skip_flag; registerPointer == 8'h0d |=> registerPointer inside {8'h0d, 8'h0f}; endproperty
a_skip_flag: assert property (p_skip_flag) else $error("flag register not skipped");
endmodule // cip_port_chk
bind cip_charger_i2c_register_port cip_port_chk chk (.clock, .rst_n, .sdaOut, .sdaOe, .chargeEnablePinN,
    .detectDone, .detectLimit, .watchdogExpired, .inputHighImpedanceEnable, .inputCurrentLimit,
    .boostSourceEnable, .chargeActive, .watchdogRestartPulse, .registerPointer);

// file: tb/tb_charger_i2c_register_port.sv
// Self-checking bench of the charger two-wire register port
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared = nCompared + 1; if ((g) !== (e)) begin badCount = badCount + 1; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_charger_i2c_register_port;
reg clock = 1'b0;
reg rst_n = 1'b0;
reg pinN = 1'b0;
reg detDone = 1'b0;
reg [4:0] detLim = 5'h00;
reg wdExp = 1'b0;
wire scl, pull, sdaOut, sdaOe, hiz, pfm, boost, chg, wdPulse;
wire [1:0] stat;
wire [4:0] ilim;
wire [2:0] sysMin;
wire [7:0] ptr;
// Open-drain data wire with pull-up
wire sda = !(pull | sdaOe);
integer seed = 32'h435d385d;
integer badCount, nCompared, i;
reg [7:0] m0, m1, d, q;
reg a;
integer pulseCnt = 0;
integer expPulse = 0;
always #50 clock = ~clock;
// Count restart pulses seen from the design
always @(posedge clock) begin
    if (wdPulse === 1'b1) begin
        pulseCnt <= pulseCnt + 1;
    end
end
cip_charger_i2c_register_port dut (.clock(clock), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .chargeEnablePinN(pinN), .detectDone(detDone), .detectLimit(detLim), .watchdogExpired(wdExp),
    .inputHighImpedanceEnable(hiz), .statusPinFunctionSelect(stat), .inputCurrentLimit(ilim),
    .lightLoadModulationDisable(pfm), .boostSourceEnable(boost), .chargeActive(chg), .minSystemVoltage(sysMin),
    .watchdogRestartPulse(wdPulse), .registerPointer(ptr));
cip_host_model host (.scl(scl), .pull(pull), .sda(sda));
// Model read value and pointer step
function [7:0] expRd(input [7:0] p);
    expRd = (p == 8'h00) ? m0 : (p == 8'h01) ? m1 : (p > 8'h0f) ? 8'hff : 8'h00;
endfunction
function [7:0] nxt(input [7:0] p);
    nxt = (p == 8'h08 || p == 8'h0d) ? p + 8'h02 : p + 8'h01;
endfunction
// Verdict and end of run
task results;
    begin
        $display("compared %0d mismatched %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask
// Field outputs against the model
task chkF;
    begin
        `CHK({hiz, stat, ilim}, m0)
        `CHK({pfm, boost, sysMin}, {m1[7], m1[5], m1[3:1]})
        `CHK(chg, m1[4] & !pinN & !m1[5])
    end
endtask
// Pointer then n data bytes, written or read back
task txn(input [7:0] p, input integer n, input rd);
    integer k;
    begin
        host.start;
        host.xfer(8'h34, 1'b1, q, a);
        `CHK(a, 1'b0)
        host.xfer(p, 1'b1, q, a);
        if (rd) begin
            host.start;
            host.xfer(8'h35, 1'b1, q, a);
            `CHK(a, 1'b0)
        end
        for (k = 0; k < n; k = k + 1) begin
            d = $random(seed);
            host.xfer(rd ? 8'hff : d, rd ? (k == n - 1) : 1'b1, q, a);
            if (rd) begin
                `CHK(q, expRd(p))
            end else begin
                `CHK(a, 1'b0)
                if (p == 8'h00) m0 = d;
                if (p == 8'h01) begin
                    m1 = d & 8'hbf;
                    expPulse = expPulse + d[6];
                end
            end
            p = nxt(p);
        end
        host.stop;
        if (!rd) `CHK(ptr, p)
    end
endtask
// Hang guard
initial begin
    repeat (100000) @(posedge clock);
    badCount = badCount + 1;
    results;
end
// Main sequence
initial begin
    badCount = 0;
    nCompared = 0;
    m0 = 8'h17;
    m1 = 8'h1a;
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clock);
    #1 chkF;
    $display("reset values done");
    // detection completes before any host write
    @(posedge clock) #1 detLim = $random(seed);
    detDone = 1'b1;
    @(posedge clock) #1 detDone = 1'b0;
    m0[4:0] = detLim;
    repeat (3) @(posedge clock);
    #1 chkF;
    $display("detect done");
    host.start;
    host.xfer(8'h36, 1'b1, q, a);
    host.stop;
    `CHK(a, 1'b1)
    for (i = 0; i < 6; i = i + 1) begin
        @(posedge clock) #1 pinN = $random(seed);
        txn(8'h00, 2, 1'b0);
        chkF;
        txn(8'h00, 2, 1'b1);
    end
    $display("write and read done");
    txn(8'h08, 2, 1'b0);
    txn(8'h0d, 1, 1'b1);
    txn(8'h0f, 2, 1'b1);
    $display("pointer skip done");
    @(posedge clock) #1 wdExp = 1'b1;
    @(posedge clock) #1 wdExp = 1'b0;
    m0[7] = 1'b0;
    m1 = (m1 & 8'h8f) | 8'h10;
    repeat (3) @(posedge clock);
    #1 chkF;
    `CHK(pulseCnt, expPulse)
    $display("watchdog done");
    results;
end
endmodule // tb_charger_i2c_register_port

// file: verilog/cip_charger_i2c_register_port.v
// Two-wire target port with the input-source and charge-system control registers
`timescale 1ns/10ps
`include "cip_regs.vh"
module cip_charger_i2c_register_port (
    clock,
    rst_n,
    sclIn,
    sdaIn,
    sdaOut,
    sdaOe,
    chargeEnablePinN,
    detectDone,
    detectLimit,
    watchdogExpired,
    inputHighImpedanceEnable,
    statusPinFunctionSelect,
    inputCurrentLimit,
    lightLoadModulationDisable,
    boostSourceEnable,
    chargeActive,
    minSystemVoltage,
    watchdogRestartPulse,
    registerPointer
);
input wire clock;
input wire rst_n;
input wire sclIn;
input wire sdaIn;
output reg sdaOut;
output reg sdaOe;
input wire chargeEnablePinN;
input wire detectDone;
input wire [4:0] detectLimit;
input wire watchdogExpired;
output reg inputHighImpedanceEnable;
output reg [1:0] statusPinFunctionSelect;
output reg [4:0] inputCurrentLimit;
output reg lightLoadModulationDisable;
output reg boostSourceEnable;
output reg chargeActive;
output reg [2:0] minSystemVoltage;
output reg watchdogRestartPulse;
output reg [7:0] registerPointer;

// ====================================================
// States
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_PTR = 3'd2;
localparam ST_WDATA = 3'd3;
localparam ST_RDATA = 3'd4;
localparam ST_RACK = 3'd5;

// ====================================================
// Functions
// Next pointer, skipping fault and flag registers
function [7:0] nextPtr;
    input [7:0] p;
    reg [7:0] n;
    begin
        n = p + 8'h01;
        if (n == {4'h0, `CIP_REG_FAULT} || n == {4'h0, `CIP_REG_FLAG}) begin
            n = n + 8'h01;
        end
        nextPtr = n;
    end
endfunction

// ====================================================
// Pin input synchronisers
reg [2:0] sclSync_r; // Three stages for clock pin
reg [2:0] sdaSync_r; // Three stages for data pin
reg sclLvl_r; // Settled clock level
reg sdaLvl_r; // Settled data level
wire sclNew = (sclSync_r[1] == sclSync_r[2]) ? sclSync_r[2] : sclLvl_r;
wire sdaNew = (sdaSync_r[1] == sdaSync_r[2]) ? sdaSync_r[2] : sdaLvl_r;
// Settled edges of the bus clock
wire sclRise = sclNew & ~sclLvl_r;
wire sclFall = ~sclNew & sclLvl_r;
// Start and stop: data moves while the clock stays high.
// Both pins share one synchroniser depth, so their order is kept.
// host makes clock
wire startCond = sclLvl_r & sclNew & sdaLvl_r & ~sdaNew;
wire stopCond = sclLvl_r & sclNew & ~sdaLvl_r & sdaNew;

// Sample pins and settle levels
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        sclSync_r <= 3'h7;
        sdaSync_r <= 3'h7;
        sclLvl_r <= 1'b1;
        sdaLvl_r <= 1'b1;
    end else begin
        sclSync_r <= {sclSync_r[1:0], sclIn};
        sdaSync_r <= {sdaSync_r[1:0], sdaIn};
        sclLvl_r <= sclNew;
        sdaLvl_r <= sdaNew;
    end
end

// ====================================================
// Protocol state
reg [2:0] state_r; // Protocol state
reg [3:0] bitCnt_r; // Bit slot in byte, 8 is acknowledge
reg [7:0] shift_r; // Receive or transmit shifter
reg ackSlot_r; // Currently in ninth slot
reg ackDrive_r; // We pull data low this slot
reg [7:0] insrc_r; // Input source control
reg [7:0] chgsys_r; // Charge system control
reg chgIn0_r, chgIn1_r, chgIn2_r; // Charge pin sync
reg chgLvl_r; // Settled charge pin

// Read value for a pointer
function [7:0] readReg;
    input [7:0] p;
    input [7:0] r0;
    input [7:0] r1;
    begin
        if (p > `CIP_REG_LAST) begin
            readReg = `CIP_RD_BEYOND;
        end else if (p == {4'h0, `CIP_REG_INSRC}) begin
            readReg = r0;
        end else if (p == {4'h0, `CIP_REG_CHGSYS}) begin
            readReg = r1;
        end else begin
            readReg = 8'h00;
        end
    end
endfunction

// Byte the device sends next, chosen by the current pointer.
// Loaded at the close of each acknowledge slot of a read.
wire [7:0] rdByte = readReg(registerPointer, insrc_r, chgsys_r);

// Byte engine, register writes and field side effects
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        // Idle bus, registers at power-on values
        state_r <= ST_IDLE;
        bitCnt_r <= 4'h0;
        shift_r <= 8'h00;
        ackSlot_r <= 1'b0;
        ackDrive_r <= 1'b0;
        sdaOut <= 1'b0;
        sdaOe <= 1'b0;
        registerPointer <= 8'h00;
        insrc_r <= `CIP_INSRC_RST;
        chgsys_r <= `CIP_CHGSYS_RST;
        watchdogRestartPulse <= 1'b0;
    end else begin
        // Restart pulse lasts one cycle unless raised below
        watchdogRestartPulse <= 1'b0;
        if (detectDone) begin
            insrc_r[`CIP_ILIM_HI:0] <= detectLimit;
        end
        // Only fields under the watchdog masks return to power-on values
        // watchdog restores fields
        if (watchdogExpired) begin
            insrc_r <= (insrc_r & ~`CIP_INSRC_WDMASK) | (`CIP_INSRC_RST & `CIP_INSRC_WDMASK);
            chgsys_r <= (chgsys_r & ~`CIP_CHGSYS_WDMASK) | (`CIP_CHGSYS_RST & `CIP_CHGSYS_WDMASK);
        end
        // A same-cycle bus write wins; the bit then clears a cycle later
        // restart self clears
        if (chgsys_r[`CIP_WDR_BIT]) begin
            chgsys_r[`CIP_WDR_BIT] <= 1'b0;
            watchdogRestartPulse <= 1'b1;
        end
        if (startCond) begin
            state_r <= ST_ADDR;
            bitCnt_r <= 4'h0;
            ackSlot_r <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            // Stop ends the transaction and frees the line
            state_r <= ST_IDLE;
            sdaOe <= 1'b0;
        end else if (state_r != ST_IDLE && sclRise && !ackSlot_r) begin
            // Take the level that arrives with the clock rise: the settled
            // copy lags one cycle and would miss a release landing with it
            // most significant first
            shift_r <= {shift_r[6:0], sdaNew};
            bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == ST_RACK && sclRise && ackSlot_r) begin
            if (sdaNew) begin
                state_r <= ST_IDLE;
            end else begin
                state_r <= ST_RDATA;
            end
        end else if (sclFall && state_r != ST_IDLE) begin
            if (ackSlot_r) begin
                // End of acknowledge slot, release line
                ackSlot_r <= 1'b0;
                bitCnt_r <= 4'h0;
                sdaOe <= 1'b0;
                if (state_r == ST_RDATA) begin
                    shift_r <= rdByte;
                    sdaOut <= 1'b0;
                    // Open drain: pull low for a zero, most significant first
                    sdaOe <= ~rdByte[7];
                    // Count restarts so eight rises reach the answer slot
                    bitCnt_r <= 4'h0;
                end
            end else if (bitCnt_r == 4'h8) begin
                ackSlot_r <= 1'b1;
                sdaOut <= 1'b0;
                sdaOe <= 1'b0;
                case (state_r)
                    ST_ADDR: begin
                        if (shift_r[7:1] == `CIP_DEV_ADDR) begin
                            sdaOe <= 1'b1;
                            state_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                        end else begin
                            // Another target: stay silent until the next start
                            state_r <= ST_IDLE;
                        end
                    end
                    ST_PTR: begin
                        registerPointer <= shift_r;
                        sdaOe <= 1'b1;
                        state_r <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        sdaOe <= 1'b1;
                        if (registerPointer == {4'h0, `CIP_REG_INSRC}) begin
                            insrc_r <= shift_r;
                        end else if (registerPointer == {4'h0, `CIP_REG_CHGSYS}) begin
                            chgsys_r <= shift_r;
                        end
                        registerPointer <= nextPtr(registerPointer);
                    end
                    ST_RDATA: begin
                        // Transmitted byte done, host answers
                        // Line already released above for the host answer
                        state_r <= ST_RACK;
                        registerPointer <= nextPtr(registerPointer);
                    end
                    default: begin
                        // Unused codes fall back to idle
                        state_r <= ST_IDLE;
                    end
                endcase
            end else if (state_r == ST_RDATA && bitCnt_r != 4'h0) begin
                // Shift next transmit bit, open drain low for zero
                // Each rise moved the byte left, so the next bit is on top
                sdaOe <= ~shift_r[7];
                sdaOut <= 1'b0;
            end
        end
    end
end

// ====================================================
// Field outputs and charge decision
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        chgIn0_r <= 1'b1;
        chgIn1_r <= 1'b1;
        chgIn2_r <= 1'b1;
        chgLvl_r <= 1'b1;
        inputHighImpedanceEnable <= 1'b0;
        statusPinFunctionSelect <= 2'h0;
        inputCurrentLimit <= 5'h17;
        lightLoadModulationDisable <= 1'b0;
        boostSourceEnable <= 1'b0;
        chargeActive <= 1'b0;
        minSystemVoltage <= 3'h5;
    end else begin
        // Charge pin passes three stages before it counts
        chgIn0_r <= chargeEnablePinN;
        chgIn1_r <= chgIn0_r;
        chgIn2_r <= chgIn1_r;
        // Level changes once the last two stages agree
        if (chgIn1_r == chgIn2_r) begin
            chgLvl_r <= chgIn2_r;
        end
        inputHighImpedanceEnable <= insrc_r[`CIP_HIZ_BIT];
        statusPinFunctionSelect <= insrc_r[`CIP_STAT_HI:`CIP_STAT_LO];
        inputCurrentLimit <= insrc_r[`CIP_ILIM_HI:0];
        lightLoadModulationDisable <= chgsys_r[`CIP_PFM_BIT];
        // Boost request follows its bit directly
        boostSourceEnable <= chgsys_r[`CIP_BOOST_BIT];
        chargeActive <= chgsys_r[`CIP_CHG_BIT] & ~chgLvl_r & ~chgsys_r[`CIP_BOOST_BIT];
        minSystemVoltage <= chgsys_r[`CIP_SYS_HI:`CIP_SYS_LO];
    end
end

endmodule // cip_charger_i2c_register_port

// file: verilog/cip_regs.vh
// Constants for the charger two-wire register port
// Functional notes
// - Receiver acknowledges each byte in ninth slot
// - Transmitter releases data line during acknowledge
// - First byte is address plus direction
// - Direction zero writes, one reads
// - Direction fixed until repeated start
// - Byte after write address is pointer
// - Writes store and advance the pointer
// - Read uses pointer set by prior write
// - Host ack continues read, nack ends
// - Auto increment skips fault and flag registers
// - Eight-bit registers, most significant bit first
// - Bit seven of register zero disconnects input
// - Status pin mode selects follow, custom, float
// - Input current limit field, reset 10111
// - Detection result updates current limit field
// - Light-load modulation disable bit
// - Watchdog restart bit self clears
// - Boost mode overrides charge enable
// - Charge needs bit and low pin
// - Minimum system voltage code, default 101
// - Target address is 0x1A
// - Pointer beyond 0x0F reads 0xFF
`ifndef CIP_REGS_VH
`define CIP_REGS_VH
// ====================================================
// Bus address and register map
`define CIP_DEV_ADDR 7'h1a
`define CIP_REG_INSRC 4'h0
`define CIP_REG_CHGSYS 4'h1
`define CIP_REG_FAULT 4'h9
`define CIP_REG_FLAG 4'he
`define CIP_REG_LAST 8'h0f
`define CIP_RD_BEYOND 8'hff
// ====================================================
// Reset values and watchdog-reset masks
`define CIP_INSRC_RST 8'h17
`define CIP_CHGSYS_RST 8'h1a
`define CIP_INSRC_WDMASK 8'h80
`define CIP_CHGSYS_WDMASK 8'h70
// ====================================================
// Field positions
`define CIP_HIZ_BIT 7
`define CIP_STAT_HI 6
`define CIP_STAT_LO 5
`define CIP_ILIM_HI 4
`define CIP_PFM_BIT 7
`define CIP_WDR_BIT 6
`define CIP_BOOST_BIT 5
`define CIP_CHG_BIT 4
`define CIP_SYS_HI 3
`define CIP_SYS_LO 1
`endif
